// ===== hw/asf_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * asynchronous serial unit. Assumes a byte-addressed bus, one word per register.
 */
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

// Byte offsets on the register bus.
`define ASF_OFF_STATUS  5'h00
`define ASF_OFF_DATA    5'h04
`define ASF_OFF_CR1     5'h08
`define ASF_OFF_CR2     5'h0c
`define ASF_OFF_BAUD    5'h10

// Control register one fields; bit 7 is the received ninth bit.
`define ASF_CR1_T8      6
`define ASF_CR1_PDOWN   5
`define ASF_CR1_M       4
`define ASF_CR1_WAKE    3
`define ASF_CR1_PCE     2
`define ASF_CR1_PS      1
`define ASF_CR1_PIE     0

// Control register two fields.
`define ASF_CR2_TIE     7
`define ASF_CR2_TX_DONE_IRQ_ENABLE    6
`define ASF_CR2_RIE     5
`define ASF_CR2_LINE_QUIET_IRQ_ENABLE    4
`define ASF_CR2_TE      3
`define ASF_CR2_RE      2
`define ASF_CR2_RWU     1
`define ASF_CR2_SBK     0

// Reset values.
`define ASF_STATUS_RST  8'hc0
`define ASF_CR1_RST     7'h00
`define ASF_CR2_RST     8'h00
`define ASF_BAUD_RST    16'h006c

// Timing counts in sixteenth-bit ticks.
`define ASF_LAST_SUB    4'hf
`define ASF_SMP_FIRST   4'h7
`define ASF_SMP_SECOND  4'h8
`define ASF_SMP_LAST    4'h9
`define ASF_IDLE_LAST8  8'h9f
`define ASF_IDLE_LAST9  8'haf

`endif

// ===== hw/asf_pkg.sv
/*
 * Types shared by the asynchronous serial unit.
 * Assumes nothing of its surroundings.
 */
package asf_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_START = 2'h1,
		ST_DATA  = 2'h3,
		ST_STOP  = 2'h2
	} asf_frame_state_t;

	typedef enum logic [1:0] {
		KIND_DATA     = 2'h0,
		KIND_BREAK    = 2'h1,
		KIND_PREAMBLE = 2'h2
	} asf_tx_kind_t;
endpackage

// ===== hw/asf_rx_sampler.sv
/*
 * Receive bit sampler and shift register of the asynchronous serial unit.
 * Assumes one tick pulse per sixteenth of a bit and a pin from outside the clock.
 */
`timescale 1ns/1ps
`include "asf_regs.svh"

module asf_rx_sampler import asf_pkg::*; (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Control
	input  wire logic       tick,
	input  wire logic       rx_on,
	input  wire logic       nine_bits,
	// Serial pin
	input  wire logic       rx_pin,
	// Word out
	output logic            word_done,
	output logic [8:0]      word,
	output logic            noise,
	output logic            frame_err,
	output logic            idle_det,
	output logic            busy
);

	logic             sync_a;
	logic             sync_b;
	logic             sync_c;
	logic             line;
	asf_frame_state_t state;
	logic [3:0]       sub;
	logic [3:0]       cnt;
	logic [1:0]       smp;
	logic [8:0]       shreg;
	logic             noisy;
	logic [7:0]       idle_cnt;
	logic             idle_armed;
	logic             maj;
	logic             nz;

	////////////////////////////////////////////////////////////////////////////////
	// The line level changes only once two later synchroniser stages agree.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			sync_c <= 1'b1;
			line   <= 1'b1;
		end else begin
			sync_a <= rx_pin;
			sync_b <= sync_a;
			sync_c <= sync_b;
			if (sync_b == sync_c)
				line <= sync_c;
		end
	end

	assign maj  = (smp[1] & smp[0]) | (smp[1] & line) | (smp[0] & line);
	assign nz   = ~((smp[1] == smp[0]) && (smp[0] == line));
	assign busy = (state != ST_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			sub        <= 4'h0;
			cnt        <= 4'h0;
			smp        <= 2'h3;
			shreg      <= 9'h000;
			noisy      <= 1'b0;
			idle_cnt   <= 8'h00;
			idle_armed <= 1'b0;
			word_done  <= 1'b0;
			word       <= 9'h000;
			noise      <= 1'b0;
			frame_err  <= 1'b0;
			idle_det   <= 1'b0;
		end else begin
			word_done <= 1'b0;
			idle_det  <= 1'b0;
			if (!rx_on) begin
				state    <= ST_IDLE;
				idle_cnt <= 8'h00;
			end else if (tick && state == ST_IDLE) begin
				if (!line) begin
					state    <= ST_START;
					sub      <= 4'h0;
					cnt      <= 4'h0;
					noisy    <= 1'b0;
					idle_cnt <= 8'h00;
				end else if (idle_armed) begin
					idle_cnt <= idle_cnt + 8'h01;
					if (idle_cnt == (nine_bits ? `ASF_IDLE_LAST9 : `ASF_IDLE_LAST8)) begin
						idle_det   <= 1'b1;
						idle_armed <= 1'b0;
					end
				end
			end else if (tick) begin
				sub <= sub + 4'h1;
				if (sub == `ASF_SMP_FIRST || sub == `ASF_SMP_SECOND)
					smp <= {smp[0], line};
				if (sub == `ASF_SMP_LAST) begin
					case (state)
						ST_START: begin
							if (maj)
								state <= ST_IDLE;
							else
								noisy <= nz;
						end
						ST_DATA: begin
							shreg <= {maj, shreg[8:1]};
							noisy <= noisy | nz;
						end
						default: begin
							word_done  <= 1'b1;
							word       <= nine_bits ? shreg : {1'b0, shreg[8:1]};
							noise      <= noisy | nz;
							frame_err  <= ~maj;
							state      <= ST_IDLE;
							idle_armed <= 1'b1;
							idle_cnt   <= 8'h00;
						end
					endcase
				end
				if (sub == `ASF_LAST_SUB) begin
					case (state)
						ST_START: state <= ST_DATA;
						ST_DATA: begin
							cnt <= cnt + 4'h1;
							if (cnt == (nine_bits ? 4'h8 : 4'h7))
								state <= ST_STOP;
						end
						default: state <= state;
					endcase
				end
			end
		end
	end

endmodule

// ===== hw/asf_core.sv
/*
 * Asynchronous serial unit: status flags, control registers, transmitter,
 * interrupt request and low-power gating, behind an Avalon-MM slave.
 * Assumes one 200 MHz clock, the receive sampler below it, and a CPU that
 * supplies halt, wait and global interrupt mask levels.
 */
// How it works
// - In halt, transmit and receive stop until halt ends; no wake from halt.
// - An enabled interrupt wakes the device from wait.
// - All events share one request, each gated by enable and global mask.
// - Status reads c0 after reset.
// - Buffer-empty flag sets when holding data moves to the shifter.
// - Empty and done flags clear by status read then data write.
// - Holding data never moves while the buffer-empty flag is set.
// - Done flag sets after a data frame, never after preamble or break.
// - Ready flag sets on a readable word; status then data read clears.
// - Idle flag sets on idle line, once until ready sets again.
// - Overrun sets when ready is still set; holding data is kept.
// - Noise flag sets on a noisy frame, no interrupt of its own.
// - Framing flag has no interrupt; overrun alone is set when both occur.
// - Parity flag sets on mismatch; interrupts with its enable.
// - Ninth received bit lands in control bit 7; bit 6 is sent.
// - Power-down stops prescaler and outputs after the current byte.
// - Word-length bit picks eight or nine data bits.
// - Wake bit picks idle-line or address-mark wake-up.
// - Parity goes in the word's top bit, checked on receive, per byte.
// - Parity select picks even or odd, applied from the next byte.
// - Majority of samples eight to ten; disagreement raises noise.
// - Muted, address mark wake clears mute and receives the word.
// - Muted, idle wake clears mute without the idle flag.
`timescale 1ns/1ps
`include "asf_regs.svh"

module asf_core import asf_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// Processor context
	input  wire logic        halt_mode,
	input  wire logic        wait_mode,
	input  wire logic        global_irq_mask,
	output logic             irq,
	output logic             wait_wake,
	// Serial line
	input  wire logic        rx_pin,
	output logic             tx_out,
	output logic             tx_oe
);

	logic [6:0]       cr1;
	logic [7:0]       cr2;
	logic [15:0]      baud;
	logic             tx_buffer_empty_flag, tc, rx_ready_flag, idle_flag, or_flag, nf, fe, pe;
	logic             rx_ninth_bit;
	logic [7:0]       tx_hold;
	logic [7:0]       rx_hold;
	logic [7:0]       status;
	logic [15:0]      rd_mux;
	logic             acc, st_rd, dat_rd, dat_wr, armed, clr_tx, clr_rx;
	logic [15:0]      baud_cnt;
	logic             tick, run_en, tx_busy, rx_busy;
	asf_frame_state_t tx_state;
	asf_tx_kind_t     tx_kind;
	logic [3:0]       tx_sub, tx_cnt;
	logic [8:0]       tx_shift, tx_word;
	logic             tx_m, te_prev, pre_pend;
	logic             tx_go, tx_start, load_tx, tc_set, next_tx_line;
	logic             rx_m, rx_pce, rx_ps;
	logic             word_done, rx_noise, rx_ferr, idle_det;
	logic [8:0]       rx_word;
	logic             rx_msb, rx_perr, muted, accept, ovr, load_rx;
	logic             mute_clr, idle_armed, ev;

	assign status = {tx_buffer_empty_flag, tc, rx_ready_flag, idle_flag, or_flag, nf, fe, pe};
	assign muted  = cr2[`ASF_CR2_RWU];

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then the access is taken.
	assign acc    = (read | write) & ~waitrequest;
	assign st_rd  = acc & read & (address == `ASF_OFF_STATUS);
	assign dat_rd = acc & read & (address == `ASF_OFF_DATA);
	assign dat_wr = acc & write & (address == `ASF_OFF_DATA);
	assign clr_tx = dat_wr & armed;
	assign clr_rx = dat_rd & armed;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~(waitrequest & (read | write));
	end

	always_comb begin
		case (address)
			`ASF_OFF_STATUS: rd_mux = {8'h00, status};
			`ASF_OFF_DATA:   rd_mux = {8'h00, rx_hold};
			`ASF_OFF_CR1:    rd_mux = {8'h00, rx_ninth_bit, cr1};
			`ASF_OFF_CR2:    rd_mux = {8'h00, cr2};
			`ASF_OFF_BAUD:   rd_mux = baud;
			default:         rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			readdata <= 32'h0000_0000;
		else if (waitrequest && read)
			readdata <= {16'h0000, rd_mux};
	end

	// A status read arms the clearing; any data access disarms it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			armed <= 1'b0;
		else if (st_rd)
			armed <= 1'b1;
		else if (dat_rd || dat_wr)
			armed <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cr1     <= `ASF_CR1_RST;
			baud    <= `ASF_BAUD_RST;
			tx_hold <= 8'h00;
		end else if (acc && write) begin
			if (address == `ASF_OFF_CR1)
				cr1 <= writedata[6:0];
			if (address == `ASF_OFF_BAUD)
				baud <= writedata[15:0];
			if (address == `ASF_OFF_DATA)
				tx_hold <= writedata[7:0];
		end
	end

	// Hardware clearing of mute wins over a software write.
	assign mute_clr = muted & ((idle_det & ~cr1[`ASF_CR1_WAKE]) |
		(word_done & cr1[`ASF_CR1_WAKE] & rx_msb));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cr2 <= `ASF_CR2_RST;
		end else begin
			if (acc && write && address == `ASF_OFF_CR2)
				cr2 <= writedata[7:0];
			if (mute_clr)
				cr2[`ASF_CR2_RWU] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sixteenth-bit tick; stopped in halt and, once idle, in power-down.
	assign run_en = ~halt_mode &
		~(cr1[`ASF_CR1_PDOWN] & ~tx_busy & ~rx_busy);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt <= 16'h0000;
			tick     <= 1'b0;
		end else if (!run_en) begin
			tick <= 1'b0;
		end else if (baud_cnt >= baud) begin
			baud_cnt <= 16'h0000;
			tick     <= 1'b1;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter.
	always_comb begin
		tx_word = {cr1[`ASF_CR1_T8], tx_hold};
		if (cr1[`ASF_CR1_PCE]) begin
			if (cr1[`ASF_CR1_M])
				tx_word[8] = ^tx_hold[7:0] ^ cr1[`ASF_CR1_PS];
			else
				tx_word[7] = ^tx_hold[6:0] ^ cr1[`ASF_CR1_PS];
		end
	end

	assign tx_busy  = (tx_state != ST_IDLE);
	assign tx_go    = tick & ~tx_busy & cr2[`ASF_CR2_TE];
	assign tx_start = tx_go & (cr2[`ASF_CR2_SBK] | pre_pend | ~tx_buffer_empty_flag);
	assign load_tx  = tx_go & ~cr2[`ASF_CR2_SBK] & ~pre_pend & ~tx_buffer_empty_flag;
	assign tc_set   = tick & (tx_sub == `ASF_LAST_SUB) & (tx_state == ST_STOP) &
		(tx_kind == KIND_DATA);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= ST_IDLE;
			tx_kind  <= KIND_DATA;
			tx_sub   <= 4'h0;
			tx_cnt   <= 4'h0;
			tx_shift <= 9'h1ff;
			tx_m     <= 1'b0;
		end else if (tx_start) begin
			tx_state <= ST_START;
			tx_sub   <= 4'h0;
			tx_cnt   <= 4'h0;
			tx_m     <= cr1[`ASF_CR1_M];
			tx_shift <= tx_word;
			tx_kind  <= cr2[`ASF_CR2_SBK] ? KIND_BREAK :
				(pre_pend ? KIND_PREAMBLE : KIND_DATA);
		end else if (tick && tx_busy) begin
			tx_sub <= tx_sub + 4'h1;
			if (tx_sub == `ASF_LAST_SUB) begin
				case (tx_state)
					ST_START: tx_state <= ST_DATA;
					ST_DATA: begin
						tx_shift <= {1'b1, tx_shift[8:1]};
						tx_cnt   <= tx_cnt + 4'h1;
						if (tx_cnt == (tx_m ? 4'h8 : 4'h7))
							tx_state <= ST_STOP;
					end
					default: tx_state <= ST_IDLE;
				endcase
			end
		end
	end

	// Raising the transmit enable queues one preamble frame.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			te_prev  <= 1'b0;
			pre_pend <= 1'b0;
		end else begin
			te_prev <= cr2[`ASF_CR2_TE];
			if (cr2[`ASF_CR2_TE] && !te_prev)
				pre_pend <= 1'b1;
			else if (tx_go && !cr2[`ASF_CR2_SBK])
				pre_pend <= 1'b0;
		end
	end

	always_comb begin
		case (tx_state)
			ST_START: next_tx_line = (tx_kind == KIND_PREAMBLE);
			ST_DATA:  next_tx_line = (tx_kind == KIND_DATA) ? tx_shift[0] :
				(tx_kind == KIND_PREAMBLE);
			ST_STOP:  next_tx_line = (tx_kind != KIND_BREAK);
			default:  next_tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= 1'b1;
			tx_oe  <= 1'b0;
		end else begin
			tx_out <= next_tx_line;
			tx_oe  <= (cr2[`ASF_CR2_TE] | tx_busy) &
				~(cr1[`ASF_CR1_PDOWN] & ~tx_busy & ~rx_busy);
		end
	end

	// Transmit flags; a hardware set wins over the clearing sequence.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_buffer_empty_flag <= 1'b1;
			tc   <= 1'b1;
		end else begin
			if (clr_tx) begin
				tx_buffer_empty_flag <= 1'b0;
				tc   <= 1'b0;
			end
			if (load_tx)
				tx_buffer_empty_flag <= 1'b1;
			if (tc_set)
				tc <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver. Frame format is taken only between words.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_m   <= 1'b0;
			rx_pce <= 1'b0;
			rx_ps  <= 1'b0;
		end else if (!rx_busy) begin
			rx_m   <= cr1[`ASF_CR1_M];
			rx_pce <= cr1[`ASF_CR1_PCE];
			rx_ps  <= cr1[`ASF_CR1_PS];
		end
	end

	asf_rx_sampler u_rx (
		.clock     (clock),
		.rst_n     (rst_n),
		.tick      (tick),
		.rx_on     (cr2[`ASF_CR2_RE]),
		.nine_bits (rx_m),
		.rx_pin    (rx_pin),
		.word_done (word_done),
		.word      (rx_word),
		.noise     (rx_noise),
		.frame_err (rx_ferr),
		.idle_det  (idle_det),
		.busy      (rx_busy)
	);

	assign rx_msb  = rx_m ? rx_word[8] : rx_word[7];
	assign rx_perr = rx_pce & ((rx_m ? ^rx_word[8:0] : ^rx_word[7:0]) ^ rx_ps);
	assign accept  = word_done & (~muted | (cr1[`ASF_CR1_WAKE] & rx_msb));
	assign ovr     = accept & rx_ready_flag & ~clr_rx;
	assign load_rx = accept & ~ovr;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_hold      <= 8'h00;
			rx_ninth_bit <= 1'b0;
		end else if (load_rx) begin
			rx_hold <= rx_word[7:0];
			if (rx_m)
				rx_ninth_bit <= rx_word[8];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_ready_flag      <= 1'b0;
			or_flag   <= 1'b0;
			nf        <= 1'b0;
			fe        <= 1'b0;
			pe        <= 1'b0;
			idle_flag <= 1'b0;
		end else begin
			if (clr_rx) begin
				rx_ready_flag      <= 1'b0;
				or_flag   <= 1'b0;
				nf        <= 1'b0;
				fe        <= 1'b0;
				pe        <= 1'b0;
				idle_flag <= 1'b0;
			end
			if (load_rx) begin
				rx_ready_flag <= 1'b1;
				if (rx_noise)
					nf <= 1'b1;
				if (rx_ferr)
					fe <= 1'b1;
				if (rx_perr)
					pe <= 1'b1;
			end
			if (ovr)
				or_flag <= 1'b1;
			if (idle_det && !muted && idle_armed)
				idle_flag <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			idle_armed <= 1'b1;
		else if (load_rx)
			idle_armed <= 1'b1;
		else if (idle_det && !muted)
			idle_armed <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt request and wait wake-up.
	assign ev = (tx_buffer_empty_flag & cr2[`ASF_CR2_TIE]) | (tc & cr2[`ASF_CR2_TX_DONE_IRQ_ENABLE]) |
		((rx_ready_flag | or_flag) & cr2[`ASF_CR2_RIE]) | (idle_flag & cr2[`ASF_CR2_LINE_QUIET_IRQ_ENABLE]) |
		(pe & cr1[`ASF_CR1_PIE]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq       <= 1'b0;
			wait_wake <= 1'b0;
		end else begin
			irq       <= ev & ~global_irq_mask & ~halt_mode;
			wait_wake <= ev & ~global_irq_mask & ~halt_mode & wait_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_reset_status;
		@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> status == `ASF_STATUS_RST;
	endproperty
	a_reset_status: assert property (p_reset_status) else $error("status not c0 after reset");

	property p_load_sets_empty;
		@(posedge clock) disable iff (!rst_n)
		load_tx |-> !tx_buffer_empty_flag ##1 tx_buffer_empty_flag && tx_state == ST_START;
	endproperty
	a_load_sets_empty: assert property (p_load_sets_empty) else $error("empty flag not set on load");

	property p_no_load_when_empty;
		@(posedge clock) disable iff (!rst_n)
		tx_buffer_empty_flag |-> !load_tx && !(tx_start && !cr2[`ASF_CR2_SBK] && !pre_pend);
	endproperty
	a_no_load_when_empty: assert property (p_no_load_when_empty) else $error("loaded while empty");

	property p_done_only_data;
		@(posedge clock) disable iff (!rst_n)
		$rose(tc) |-> $past(tx_state) == ST_STOP && $past(tx_kind) == KIND_DATA;
	endproperty
	a_done_only_data: assert property (p_done_only_data) else $error("done after non-data frame");

	property p_clear_tx;
		@(posedge clock) disable iff (!rst_n)
		st_rd ##[1:20] (dat_wr && !load_tx && !tc_set) |=> !tx_buffer_empty_flag && !tc;
	endproperty
	a_clear_tx: assert property (p_clear_tx) else $error("transmit flags not cleared");

	property p_overrun_keeps;
		@(posedge clock) disable iff (!rst_n)
		ovr |=> or_flag && $stable(rx_hold) && !$rose(fe);
	endproperty
	a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun lost holding data");

	property p_halt_quiet;
		@(posedge clock) disable iff (!rst_n)
		halt_mode [*2] |-> !irq && !tick;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("activity during halt");

	property p_mark_wakes;
		@(posedge clock) disable iff (!rst_n)
		word_done && muted && cr1[`ASF_CR1_WAKE] && rx_msb |=> !muted && (rx_ready_flag || or_flag);
	endproperty
	a_mark_wakes: assert property (p_mark_wakes) else $error("address mark did not wake");

	property p_wait_wake;
		@(posedge clock) disable iff (!rst_n)
		ev && wait_mode && !global_irq_mask && !halt_mode |=> wait_wake && irq;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait");

endmodule

// ===== dv/asf_far_end.sv
/*
 * Far-end serial station: sends 8-bit frames on the unit's receive line and
 * decodes frames seen on its transmit pin. Assumes BIT_CLK clocks per bit.
 */
`timescale 1ns/1ps
module asf_far_end #(
	parameter int BIT_CLK = 16
) (
	// Clock
	input  wire logic clock,
	// Serial line
	input  wire logic tx_out,
	input  wire logic tx_oe,
	output logic      rx_line
);
	logic [7:0] got;
	int         n_got;

	initial begin
		rx_line = 1'b1;
		got = 8'h00;
		n_got = 0;
	end

	// Start bit, eight bits LSB first, stop bit; the line idles high.
	task automatic send(input logic [7:0] b);
		rx_line <= 1'b0;
		repeat (BIT_CLK) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			rx_line <= b[i];
			repeat (BIT_CLK) @(posedge clock);
		end
		rx_line <= 1'b1;
		repeat (BIT_CLK) @(posedge clock);
	endtask

	// Samples each bit in its middle, counted from the start edge.
	always @(negedge tx_out) begin
		if (tx_oe === 1'b1) begin
			repeat (BIT_CLK / 2) @(posedge clock);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLK) @(posedge clock);
				got[i] = tx_out;
			end
			n_got++;
		end
	end
endmodule

// ===== dv/tb_async_serial_status_and_frame_control.sv
/*
 * Self-checking bench of the serial unit core.
 * Assumes the far-end model on the line and a divisor of 0 (16 clocks a bit).
 */
`timescale 1ns/1ps
module tb_async_serial_status_and_frame_control;
	localparam int BIT = 16;
	logic        clock;
	logic        rst_n;
	logic [4:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        halt_mode;
	logic        wait_mode;
	logic        global_irq_mask;
	logic        irq;
	logic        wait_wake;
	logic        rx_pin;
	logic        tx_out;
	logic        tx_oe;
	logic [7:0]  q;
	int          n_mismatch;
	int          check_count;

	asf_core u_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .halt_mode(halt_mode), .wait_mode(wait_mode),
		.global_irq_mask(global_irq_mask), .irq(irq), .wait_wake(wait_wake),
		.rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe));

	asf_far_end #(.BIT_CLK(BIT)) u_far (.clock(clock), .tx_out(tx_out), .tx_oe(tx_oe),
		.rx_line(rx_pin));

	always #2.5 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		writedata <= {24'h000000, d};
		write <= wr;
		read <= ~wr;
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hc0);
		bus(1'b0, 5'h14, 8'h00);
		chk(q, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_tx;
		int n0;
		n0 = u_far.n_got;
		bus(1'b0, 5'h00, 8'h00);
		bus(1'b1, 5'h04, 8'ha5);
		bus(1'b0, 5'h00, 8'h00);
		chk(q & 8'h40, 8'h00);
		while (u_far.n_got == n0) @(posedge clock);
		chk(u_far.got, 8'ha5);
		repeat (2 * BIT) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hc0);
		$display("test tx done");
	endtask

	task automatic t_rx;
		u_far.send(8'h3c);
		repeat (4) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'he0);
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'h3c);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hc0);
		repeat (12 * BIT) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hd0);
		bus(1'b0, 5'h04, 8'h00);
		repeat (12 * BIT) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hc0);
		$display("test rx done");
	endtask

	task automatic t_ovr;
		u_far.send(8'h11);
		u_far.send(8'h22);
		repeat (4) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'he8);
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'h11);
		$display("test overrun done");
	endtask

	task automatic t_par;
		// Format is changed only while the line is quiet.
		bus(1'b1, 5'h08, 8'h05);
		u_far.send(8'h01);
		repeat (4) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'he1);
		chk({7'h00, irq}, 8'h01);
		global_irq_mask <= 1'b1;
		repeat (3) @(posedge clock);
		chk({7'h00, irq}, 8'h00);
		global_irq_mask <= 1'b0;
		wait_mode <= 1'b1;
		repeat (3) @(posedge clock);
		chk({7'h00, wait_wake}, 8'h01);
		halt_mode <= 1'b1;
		repeat (3) @(posedge clock);
		chk({7'h00, irq}, 8'h00);
		halt_mode <= 1'b0;
		wait_mode <= 1'b0;
		bus(1'b0, 5'h04, 8'h00);
		bus(1'b1, 5'h08, 8'h00);
		bus(1'b1, 5'h0c, 8'h8c);
		repeat (3) @(posedge clock);
		chk({7'h00, irq}, 8'h01);
		$display("test parity and irq done");
	endtask

	task automatic t_mute;
		bus(1'b1, 5'h08, 8'h08);
		bus(1'b1, 5'h0c, 8'h0e);
		u_far.send(8'h05);
		repeat (4) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'hc0);
		u_far.send(8'h85);
		repeat (4) @(posedge clock);
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 8'he0);
		bus(1'b0, 5'h0c, 8'h00);
		chk(q, 8'h0c);
		bus(1'b0, 5'h04, 8'h00);
		chk(q, 8'h85);
		$display("test mute wake done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop;
	end

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		address = 5'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		halt_mode = 1'b0;
		wait_mode = 1'b0;
		global_irq_mask = 1'b0;
		q = 8'h00;
		n_mismatch = 0;
		check_count = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		bus(1'b1, 5'h10, 8'h00);
		bus(1'b1, 5'h0c, 8'h0c);
		repeat (12 * BIT) @(posedge clock);
		t_tx;
		t_rx;
		t_ovr;
		t_par;
		t_mute;
		report_and_stop;
	end
endmodule
